// >>> logic/asp_pkg.sv
// Package with register map, field layouts and constants of the servo loop
package asp_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] ASP_CTRL_OFS    = 8'h00;
  localparam logic [7:0] ASP_LIMITS_OFS  = 8'h04;
  localparam logic [7:0] ASP_FILL_OFS    = 8'h08;
  localparam logic [7:0] ASP_GAINS_OFS   = 8'h0C;
  localparam logic [7:0] ASP_CORR_OFS    = 8'h10;
  localparam logic [7:0] ASP_CURR_OFS    = 8'h14;
  localparam logic [7:0] ASP_DELAY_OFS   = 8'h18;
  localparam logic [7:0] ASP_TEST_OFS    = 8'h1C;
  localparam logic [7:0] ASP_TFREQ_OFS   = 8'h20;
  localparam logic [7:0] ASP_CURVE_OFS   = 8'h24;
  localparam logic [7:0] ASP_POS_OFS     = 8'h28;
  localparam logic [7:0] ASP_STAT_OFS    = 8'h2C;
  // Control register fields
  localparam int ASP_CTRL_ACT_EN  = 0;
  localparam int ASP_CTRL_CURVE   = 1;
  localparam int ASP_CTRL_TEST_EN = 2;
  // Positions are 0..1000 in 0.1 % steps
  localparam logic [15:0] ASP_POS_FULL     = 16'h03E8;
  localparam logic [15:0] ASP_SEC_MIN_RST  = 16'h001E; // 3.0 %
  localparam logic [15:0] ASP_SEC_MAX_RST  = 16'h03CA; // 97.0 %
  localparam logic [7:0]  ASP_UNITY_FACTOR = 8'h80;    // 100 % in Q1.7
  localparam logic [15:0] ASP_IMAX_RST     = 16'h0FFF;
  localparam logic [15:0] ASP_IRED_RST     = 16'h0400;
  // Waveform selections
  localparam logic [1:0]  ASP_WAVE_FIXED   = 2'h0;
  localparam logic [1:0]  ASP_WAVE_SQUARE  = 2'h1;
  localparam logic [1:0]  ASP_WAVE_TRI     = 2'h2;
  // Current reduction time constant
  localparam int ASP_CLK_HZ       = 40000000;
  localparam int ASP_TAU_S        = 60;
  localparam int ASP_TAU_SHIFT    = 10;  // decay step = diff >> shift
  // Loop update every ASP_LOOP_CYC clock cycles
  localparam int ASP_LOOP_CYC     = 400;
endpackage

// >>> logic/asp_servo.sv
// Actuator position servo: setpoint path, PID+DD loop, current limiting
`timescale 1ns/10ps
// Behaviour
// - Commanded position never falls below secure_min_position (typically 3 %) unless secure_max_position is lower.
// - Commanded position never exceeds secure_max_position (typically 97 %).
// - Linear linkage passes filling_setpoint straight to position_setpoint.
// - With curve selected, position setpoint comes from the filling curve.
// - Loop sums P, I, D and an acceleration-opposing DD term, each gained.
// - Within correction range all loop gains scale by the correction factor.
// - Beyond twice the range unity; between, factor interpolates smoothly.
// - Factor 100 % leaves gains unchanged; applied factor is readable.
// - Current setpoint derives from loop output, clamped to maximum current.
// - Static load lowers allowed current exponentially to reduced current.
// - Reduction begins after the start delay; zero delay starts at once.
// - A dynamic setpoint change restores the full maximum current.
// - Winding driven by current amplifier tracking the current setpoint.
// - Test mode refused unless actuator_enable is set.
// - Test mode leaves when setpoint generator nonzero without stop input.
// - Test mode enable is not retained; reads inactive after reset.
// - Writing one to test_mode_enable replaces setpoint with test generator.
// - Waveform zero outputs the fixed test setpoint.
// - Waveform one squares between setpoint plus and minus amplitude.
// - Waveform two forms a triangle around the test setpoint.
// - Square and triangle repeat at the configured test frequency.
// - Scaled feedback is always readable as the actual position.
module asp_servo
#(
  parameter int LOOP_CYC = asp_pkg::ASP_LOOP_CYC, // Clocks per loop step
  parameter int TAU_CYC  = asp_pkg::ASP_CLK_HZ / (1 << asp_pkg::ASP_TAU_SHIFT)
                           * asp_pkg::ASP_TAU_S // Clocks per decay step
)
(
  input  wire logic        clk,            // 40 MHz clock
  input  wire logic        rst_b,          // Async reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB write
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error
  input  wire logic [15:0] feedback_pos,   // Scaled feedback, 0.1 %
  input  wire logic [15:0] setpoint_gen,   // External setpoint generator
  input  wire logic        ext_stop,       // External stop request
  input  wire logic [15:0] winding_current,// Measured winding current
  output logic      [15:0] position_setpoint, // Clamped set position
  output logic      [15:0] current_setpoint,  // Loop current request
  output logic signed [15:0] drive_level      // Amplifier drive
);
  import asp_pkg::*;

  // Counters are 16 and 32 bits wide; refuse steps they cannot hold
  if (LOOP_CYC < 2 || LOOP_CYC > 65536 || TAU_CYC < 1)
  begin : g_param_check
    $error("asp_servo: bad cycle parameters");
  end

  // Software registers
  logic [2:0]  ctrl_reg;
  logic [31:0] limits_reg, fill_reg, gains_reg, corr_reg, curr_reg;
  logic [31:0] delay_reg, test_reg, tfreq_reg, curve_reg;
  // Loop state
  logic [15:0] actual_position;
  logic [15:0] prev_set_reg;
  logic signed [31:0] integ_reg;
  logic signed [16:0] err1_reg, err2_reg;
  logic [15:0] allowed_reg;
  logic [31:0] static_cnt_reg;
  logic [15:0] loop_cnt_reg;
  logic [31:0] tau_cnt_reg;
  logic [31:0] wave_cnt_reg;
  logic        wave_phase_reg;
  logic [15:0] tri_reg;
  logic        tri_up_reg;
  logic [7:0]  applied_gain_factor;

  // Field views
  wire [15:0] secure_min_position = limits_reg[15:0];
  wire [15:0] secure_max_position = limits_reg[31:16];
  wire [15:0] filling_setpoint    = fill_reg[15:0];
  wire [7:0]  loop_p_gain  = gains_reg[7:0];
  wire [7:0]  loop_i_gain  = gains_reg[15:8];
  wire [7:0]  loop_d_gain  = gains_reg[23:16];
  wire [7:0]  loop_dd_gain = gains_reg[31:24];
  wire [15:0] gain_correction_range  = corr_reg[15:0];
  wire [7:0]  gain_correction_factor = corr_reg[23:16];
  wire [15:0] max_current_limit      = curr_reg[15:0];
  wire [15:0] reduced_static_current = curr_reg[31:16];
  wire [31:0] reduction_start_delay  = delay_reg;
  wire [15:0] test_setpoint        = test_reg[15:0];
  wire [13:0] test_amplitude       = test_reg[29:16];
  wire [1:0]  test_waveform_select = test_reg[31:30];
  wire [31:0] test_frequency       = tfreq_reg; // Clocks per half period, less one
  wire [15:0] curve_slope          = curve_reg[15:0]; // Q8.8
  wire [15:0] curve_offset         = curve_reg[31:16];
  wire        actuator_enable  = ctrl_reg[ASP_CTRL_ACT_EN];
  wire        test_mode_enable = ctrl_reg[ASP_CTRL_TEST_EN];
  assign actual_position = feedback_pos;

  // APB decode; zero wait states
  wire apb_wr = psel && penable && pwrite;
  wire hit_ctrl  = paddr == ASP_CTRL_OFS;
  wire hit_lim   = paddr == ASP_LIMITS_OFS;
  wire hit_fill  = paddr == ASP_FILL_OFS;
  wire hit_gain  = paddr == ASP_GAINS_OFS;
  wire hit_corr  = paddr == ASP_CORR_OFS;
  wire hit_curr  = paddr == ASP_CURR_OFS;
  wire hit_delay = paddr == ASP_DELAY_OFS;
  wire hit_test  = paddr == ASP_TEST_OFS;
  wire hit_tfreq = paddr == ASP_TFREQ_OFS;
  wire hit_curve = paddr == ASP_CURVE_OFS;
  wire hit_pos   = paddr == ASP_POS_OFS;
  wire hit_stat  = paddr == ASP_STAT_OFS;
  wire hit_any = hit_ctrl || hit_lim || hit_fill || hit_gain || hit_corr
    || hit_curr || hit_delay || hit_test || hit_tfreq || hit_curve
    || hit_pos || hit_stat;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // Test mode exit on live setpoint generator without a stop
  wire test_abort = (setpoint_gen != 16'h0000) && !ext_stop;
  wire test_req   = apb_wr && hit_ctrl && pwdata[ASP_CTRL_TEST_EN];
  // Test enable only taken with actuator on
  wire test_next = test_abort ? 1'b0 :
    (apb_wr && hit_ctrl) ? (test_req && pwdata[ASP_CTRL_ACT_EN]) :
    (test_mode_enable && actuator_enable);

  // Register writes; test enable resets to off and is loaded from test_next each clock
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_reg   <= 3'h0;
      limits_reg <= {ASP_SEC_MAX_RST, ASP_SEC_MIN_RST};
      fill_reg   <= 32'h0;
      gains_reg  <= 32'h00000000;
      corr_reg   <= {8'h00, ASP_UNITY_FACTOR, 16'h0000};
      curr_reg   <= {ASP_IRED_RST, ASP_IMAX_RST};
      delay_reg  <= 32'h0;
      test_reg   <= 32'h0;
      tfreq_reg  <= 32'h0;
      curve_reg  <= 32'h01000000;
    end
    else
    begin
      ctrl_reg[ASP_CTRL_TEST_EN] <= test_next;
      if (apb_wr && hit_ctrl)
        ctrl_reg[1:0] <= pwdata[1:0];
      if (apb_wr && hit_lim)   limits_reg <= pwdata;
      if (apb_wr && hit_fill)  fill_reg   <= pwdata;
      if (apb_wr && hit_gain)  gains_reg  <= pwdata;
      if (apb_wr && hit_corr)  corr_reg   <= pwdata;
      if (apb_wr && hit_curr)  curr_reg   <= pwdata;
      if (apb_wr && hit_delay) delay_reg  <= pwdata;
      if (apb_wr && hit_test)  test_reg   <= pwdata;
      if (apb_wr && hit_tfreq) tfreq_reg  <= pwdata;
      if (apb_wr && hit_curve) curve_reg  <= pwdata;
    end
  end

  // Read mux; unmapped reads zero
  wire [31:0] stat_word = {8'h00, applied_gain_factor, allowed_reg};
  assign prdata = hit_ctrl  ? {29'h0, ctrl_reg} :
                  hit_lim   ? limits_reg :
                  hit_fill  ? fill_reg   :
                  hit_gain  ? gains_reg  :
                  hit_corr  ? corr_reg   :
                  hit_curr  ? curr_reg   :
                  hit_delay ? delay_reg  :
                  hit_test  ? test_reg   :
                  hit_tfreq ? tfreq_reg  :
                  hit_curve ? curve_reg  :
                  hit_pos   ? {current_setpoint, actual_position} :
                  hit_stat  ? stat_word  : 32'h0;

  // Setpoint from filling: linear or curve (slope Q8.8 plus offset)
  wire [31:0] curve_prod = filling_setpoint * curve_slope;
  wire [16:0] curve_sum  = {1'b0, curve_prod[23:8]} + {1'b0, curve_offset};
  wire [15:0] curve_pos  = curve_sum[16] ? 16'hFFFF : curve_sum[15:0];
  wire [15:0] normal_set = ctrl_reg[ASP_CTRL_CURVE] ? curve_pos
                                                    : filling_setpoint;

  // Test generator; signed arithmetic keeps the low swing from wrapping
  wire signed [17:0] tset  = $signed({2'b00, test_setpoint});
  wire signed [17:0] tamp  = $signed({4'b0000, test_amplitude});
  wire signed [17:0] sq_v  = wave_phase_reg ? tset + tamp : tset - tamp;
  wire signed [17:0] tri_v = tset - tamp + $signed({2'b00, tri_reg});
  wire signed [17:0] test_v =
    (test_waveform_select == ASP_WAVE_SQUARE) ? sq_v :
    (test_waveform_select == ASP_WAVE_TRI)    ? tri_v : tset;
  wire [15:0] test_pos = test_v < 0 ? 16'h0000 : test_v[15:0];

  // Selection first, clamps after so test waves stay in bounds
  wire [15:0] sel_set = test_mode_enable ? test_pos : normal_set;
  wire [15:0] lo_set = sel_set < secure_min_position ?
                       secure_min_position : sel_set;
  wire [15:0] clamped_set = lo_set > secure_max_position ?
                            secure_max_position : lo_set;

  // Loop tick divider
  wire loop_tick = loop_cnt_reg == 16'(LOOP_CYC - 1);

  // Waveform timing: phase flips every test_frequency + 1 clocks
  wire wave_tick = wave_cnt_reg >= test_frequency;
  wire [15:0] tri_span = {1'b0, test_amplitude, 1'b0};
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wave_cnt_reg   <= 32'h0;
      wave_phase_reg <= 1'b0;
      tri_reg        <= 16'h0;
      tri_up_reg     <= 1'b1;
    end
    else if (!test_mode_enable)
    begin
      wave_cnt_reg   <= 32'h0;
      wave_phase_reg <= 1'b0;
      tri_reg        <= 16'h0;
      tri_up_reg     <= 1'b1;
    end
    else
    begin
      wave_cnt_reg <= wave_tick ? 32'h0 : wave_cnt_reg + 32'h1;
      if (wave_tick)
        wave_phase_reg <= !wave_phase_reg;
      // Triangle walks one step per loop tick; direction flips on each wave tick
      if (wave_tick)
        tri_up_reg <= !tri_up_reg;
      else if (loop_tick && tri_up_reg && tri_reg < tri_span)
        tri_reg <= tri_reg + 16'h1;
      else if (loop_tick && !tri_up_reg && tri_reg != 16'h0)
        tri_reg <= tri_reg - 16'h1;
    end
  end

  // Gain correction: factor vs |error| against range and twice range
  wire signed [16:0] err = $signed({1'b0, clamped_set})
                         - $signed({1'b0, actual_position});
  wire [15:0] abs_err = err < 0 ? 16'(-err) : err[15:0];
  wire [16:0] range2  = {gain_correction_range, 1'b0};
  wire [15:0] over    = abs_err - gain_correction_range;
  wire [8:0]  fdiff   = {1'b0, ASP_UNITY_FACTOR}
                      - {1'b0, gain_correction_factor};
  wire [24:0] interp_p = $signed(fdiff) * over;
  wire [24:0] interp_q = gain_correction_range == 16'h0 ? 25'h0 :
                         interp_p / gain_correction_range;
  wire [8:0]  interp_f = {1'b0, gain_correction_factor} + interp_q[8:0];
  assign applied_gain_factor =
    ({1'b0, abs_err} > range2) ? ASP_UNITY_FACTOR :
    (abs_err <= gain_correction_range) ? gain_correction_factor :
    interp_f[7:0];

  // PID with DD term, gains scaled by applied factor (unity = 128)
  wire signed [16:0] d1 = err - err1_reg;
  wire signed [16:0] d2 = err - (err1_reg <<< 1) + err2_reg;
  wire signed [31:0] pid_raw = $signed({1'b0, loop_p_gain}) * err
    + (integ_reg >>> 8)
    + $signed({1'b0, loop_d_gain}) * d1
    - $signed({1'b0, loop_dd_gain}) * d2;
  wire signed [40:0] pid_scaled =
    pid_raw * $signed({1'b0, applied_gain_factor});
  wire signed [33:0] pid_out = pid_scaled[40:7];

  // Current request clamped by allowed current
  wire signed [33:0] allowed_s = $signed({18'h0, allowed_reg});
  wire [15:0] i_mag = (pid_out > allowed_s) ? allowed_reg :
                      (pid_out < -allowed_s) ? allowed_reg :
                      (pid_out < 0 ? 16'(-pid_out) : pid_out[15:0]);
  wire set_moved = clamped_set != prev_set_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      loop_cnt_reg      <= 16'h0;
      integ_reg         <= 32'sh0;
      err1_reg          <= 17'sh0;
      err2_reg          <= 17'sh0;
      prev_set_reg      <= 16'h0;
      current_setpoint  <= 16'h0;
      position_setpoint <= ASP_SEC_MIN_RST;
    end
    else
    begin
      loop_cnt_reg <= loop_tick ? 16'h0 : loop_cnt_reg + 16'h1;
      if (loop_tick)
      begin
        prev_set_reg      <= clamped_set;
        position_setpoint <= clamped_set;
        err1_reg          <= err;
        err2_reg          <= err1_reg;
        if (actuator_enable)
          integ_reg <= integ_reg + $signed({1'b0, loop_i_gain}) * err;
        current_setpoint  <= actuator_enable ? i_mag : 16'h0;
      end
    end
  end

  // Static current reduction: delay, then exponential decay
  wire delay_done = static_cnt_reg >= reduction_start_delay;
  wire tau_tick   = tau_cnt_reg == 32'(TAU_CYC - 1);
  wire [15:0] dec_diff = allowed_reg > reduced_static_current ?
                         allowed_reg - reduced_static_current : 16'h0;
  wire [15:0] dec_shr  = dec_diff >> ASP_TAU_SHIFT;
  wire [15:0] dec_step = (dec_shr == 16'h0 && dec_diff != 16'h0) ?
                         16'h1 : dec_shr; // Never stall above floor
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      allowed_reg    <= ASP_IMAX_RST;
      static_cnt_reg <= 32'h0;
      tau_cnt_reg    <= 32'h0;
    end
    else if (set_moved && loop_tick)
    begin
      allowed_reg    <= max_current_limit;
      static_cnt_reg <= 32'h0;
      tau_cnt_reg    <= 32'h0;
    end
    else if (!delay_done)
    begin
      static_cnt_reg <= static_cnt_reg + 32'h1;
      allowed_reg    <= max_current_limit;
    end
    else
    begin
      tau_cnt_reg <= tau_tick ? 32'h0 : tau_cnt_reg + 32'h1;
      if (allowed_reg > max_current_limit)
        allowed_reg <= max_current_limit;
      else if (tau_tick)
        allowed_reg <= allowed_reg - dec_step;
    end
  end

  // Current amplifier: proportional on current error, sign from loop
  wire signed [17:0] i_err = $signed({2'b00, current_setpoint})
                           - $signed({2'b00, winding_current});
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      drive_level <= 16'sh0;
    else if (!actuator_enable)
      drive_level <= 16'sh0;
    else
      drive_level <= err1_reg < 0 ? -i_err[16:1] : i_err[16:1];
  end
endmodule

// >>> sim/asp_servo_checker.sv
// Checker for the servo position loop, bound to its top module
`timescale 1ns/10ps
module asp_servo_checker
#(
  parameter int LOOP_CYC = asp_pkg::ASP_LOOP_CYC // Clocks per loop step
)
(
  input wire logic        clk,               // Clock
  input wire logic        rst_b,             // Reset, active low
  input wire logic        psel,              // APB select
  input wire logic        penable,           // APB enable
  input wire logic        pwrite,            // APB write
  input wire logic [7:0]  paddr,             // APB address
  input wire logic [31:0] pwdata,            // APB write data
  input wire logic [31:0] prdata,            // APB read data
  input wire logic        pready,            // APB ready
  input wire logic        pslverr,           // APB error
  input wire logic [15:0] feedback_pos,      // Feedback
  input wire logic [15:0] setpoint_gen,      // Generator value
  input wire logic        ext_stop,          // Stop request
  input wire logic [15:0] position_setpoint, // Set position
  input wire logic [15:0] current_setpoint   // Current request
);
  import asp_pkg::*;
  logic        acc, rd_acc, wr_ctl, quit;
  logic [15:0] mn_q, mx_q, imax_q, fb_d, fb_dd, fb_3;
  logic [2:0]  ctl_q;
  // Access phase decode
  assign acc    = psel && penable;
  assign rd_acc = acc && !pwrite;
  assign wr_ctl = acc && pwrite && paddr == ASP_CTRL_OFS;
  assign quit   = setpoint_gen != 16'h0000 && !ext_stop;
  // Shadow of settings; the exit clear wins over a software set
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      {mx_q, mn_q}        <= {ASP_SEC_MAX_RST, ASP_SEC_MIN_RST};
      imax_q              <= ASP_IMAX_RST;
      ctl_q               <= 3'h0;
      {fb_3, fb_dd, fb_d} <= 48'h0;
    end
    else
    begin
      if (acc && pwrite && paddr == ASP_LIMITS_OFS) {mx_q, mn_q} <= pwdata;
      if (acc && pwrite && paddr == ASP_CURR_OFS) imax_q <= pwdata[15:0];
      if (wr_ctl) ctl_q[1:0] <= pwdata[1:0];
      ctl_q[2] <= !quit && (wr_ctl ? pwdata[2] && pwdata[0] : ctl_q[2]);
      {fb_3, fb_dd, fb_d} <= {fb_dd, fb_d, feedback_pos};
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Bus answers at once and flags unmapped words
  zero_wait_a: assert property (acc |-> pready)
    else $error("pready low in access phase");
  map_err_a: assert property (acc && paddr > ASP_STAT_OFS |-> pslverr)
    else $error("no error on unmapped access");
  map_ok_a: assert property (acc && paddr <= ASP_STAT_OFS &&
    paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped access");
  // Outputs stay inside the configured bounds and hold between loop steps; control and position read back
  pos_floor_a: assert property (
    $changed(position_setpoint) |-> position_setpoint >= mn_q)
    else $error("set position below secure minimum");
  pos_ceil_a: assert property (
    $changed(position_setpoint) |-> position_setpoint <= mx_q)
    else $error("set position above secure maximum");
  cur_ceil_a: assert property (
    $changed(current_setpoint) |-> current_setpoint <= imax_q)
    else $error("current request above maximum");
  loop_tick_a: assert property (
    $changed(position_setpoint) |=> $stable(position_setpoint)[*3])
    else $error("set position changed between loop steps");
  test_flag_a: assert property (
    rd_acc && paddr == ASP_CTRL_OFS |-> prdata[2:0] == ctl_q)
    else $error("control readback wrong");
  pos_read_a: assert property (rd_acc && paddr == ASP_POS_OFS &&
    feedback_pos == fb_d && fb_d == fb_dd && fb_dd == fb_3
    |-> prdata[15:0] == feedback_pos) else $error("actual position wrong");
  // Main scenarios reached
  cover property (wr_ctl && pwdata[2] && !pwdata[0]);
  cover property ($fell(ctl_q[2]) && !wr_ctl);
  cover property (acc && pslverr);
endmodule
bind asp_servo asp_servo_checker #(.LOOP_CYC(LOOP_CYC)) asp_servo_checker_i (
  .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .feedback_pos, .setpoint_gen, .ext_stop, .position_setpoint,
  .current_setpoint);

// >>> sim/asp_actuator_model.sv
// Behavioural actuator: drive moves the travel, feedback in 0.1 % steps
`timescale 1ns/10ps
module asp_actuator_model
(
  input  wire logic signed [15:0] drive_level,    // Amplifier drive
  input  wire logic               clk,            // Clock
  input  wire logic               rst_b,          // Reset, active low
  input  wire logic               freeze,         // Jam the travel
  input  wire logic        [15:0] freeze_pos,     // Jammed position
  output logic             [15:0] feedback_pos,   // Scaled feedback
  output logic             [15:0] winding_current // Current magnitude
);
  int pos;
  int tick;
  // Slow travel update keeps feedback steady across a bus read
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      pos = 500;
      tick = 0;
      feedback_pos <= 16'h01F4;
      winding_current <= 16'h0000;
    end
    else
    begin
      tick = tick + 1;
      if (freeze) pos = freeze_pos;
      else if (tick % 8 == 0) pos = pos + drive_level / 256;
      pos = pos < 0 ? 0 : pos > 1000 ? 1000 : pos;
      feedback_pos <= 16'(pos);
      winding_current <= drive_level < 0 ? -drive_level : drive_level;
    end
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the servo position loop
`timescale 1ns/10ps
module testbench;
  import asp_pkg::*;
  localparam int LC = 4; // Short loop step keeps the run brief
  logic               clk = 1'b0, rst_b = 1'b0, psel = 1'b0;
  logic               penable = 1'b0, pwrite = 1'b0, ext_stop = 1'b0;
  logic               freeze = 1'b0, pready, pslverr, err;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, prdata, rd;
  logic [15:0]        setpoint_gen = 16'h0, freeze_pos = 16'h0;
  logic [15:0]        feedback_pos, winding_current;
  logic [15:0]        position_setpoint, current_setpoint;
  logic signed [15:0] drive_level;
  int                 fails = 0, tests_run = 0, seed = 32'hffef7030;
  int                 mn = 100, mx = 900, v, lo, hi, chg, bad;
  asp_servo #(.LOOP_CYC(LC), .TAU_CYC(4)) asp_servo_i (.clk, .rst_b, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .feedback_pos, .setpoint_gen, .ext_stop, .winding_current,
    .position_setpoint, .current_setpoint, .drive_level);
  asp_actuator_model asp_actuator_model_i (.clk, .rst_b, .drive_level,
    .freeze, .freeze_pos, .feedback_pos, .winding_current);
  always #12.5 clk = ~clk;
  // Compare and count
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; idle cycle after it avoids double assignment
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic tk(int n);
    repeat (n * LC) @(posedge clk);
  endtask
  function automatic int clampv(int x);
    return x < mn ? mn : x > mx ? mx : x;
  endfunction
  // Watch the set position; a square may show only its two levels
  task automatic scan(int n, int a, int b, bit sq);
    int p;
    p = position_setpoint;
    {lo, hi, chg, bad} = {32'hFFFF, 96'h0};
    repeat (n)
    begin
      @(posedge clk);
      chg += (position_setpoint != p);
      p = position_setpoint;
      lo = p < lo ? p : lo;
      hi = p > hi ? p : hi;
      bad += (p < a || p > b || (sq && p != a && p != b));
    end
  endtask
  task automatic end_of_test;
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(0, ASP_LIMITS_OFS, 32'h0);
    check("limits", rd, {ASP_SEC_MAX_RST, ASP_SEC_MIN_RST});
    apb(0, ASP_CTRL_OFS, 32'h0);
    check("test_en", rd[2], 1'b0);
    apb(0, ASP_STAT_OFS, 32'h0);
    check("factor", rd[23:16], ASP_UNITY_FACTOR);
    apb(0, 8'h30, 32'h0);
    check("slverr", err, 1'b1);
    check("unmapped", rd, 32'h0);
    apb(1, ASP_LIMITS_OFS, {16'(mx), 16'(mn)});
    apb(1, ASP_GAINS_OFS, $random(seed));
    apb(1, ASP_CTRL_OFS, 32'h1);
    // Linear path, both clamp ends first
    for (int i = 0; i < 8; i++)
    begin
      v = i == 0 ? 0 : i == 1 ? 1000 : {$random(seed)} % 1001;
      apb(1, ASP_FILL_OFS, v);
      tk(3);
      check("linear", position_setpoint, clampv(v));
    end
    apb(1, ASP_CURVE_OFS, {16'h0064, 16'h0100});
    apb(1, ASP_CTRL_OFS, 32'h3);
    for (int i = 400; i < 1000; i += 500)
    begin
      apb(1, ASP_FILL_OFS, i);
      tk(3);
      check("curve", position_setpoint, clampv(i + 100));
    end
    // Test mode refused without the actuator enabled
    apb(1, ASP_CTRL_OFS, 32'h4);
    apb(0, ASP_CTRL_OFS, 32'h0);
    check("refused", rd[2], 1'b0);
    tk(1);
    check("cur_off", current_setpoint, 0);
    check("drive_off", drive_level, 0);
    apb(1, ASP_TEST_OFS, {2'h0, 14'h0, 16'h03E8});
    apb(1, ASP_CTRL_OFS, 32'h5);
    apb(0, ASP_CTRL_OFS, 32'h0);
    check("test_on", rd[2], 1'b1);
    tk(3);
    check("fixed", position_setpoint, mx);
    freeze_pos <= 16'h0141;
    freeze <= 1'b1;
    tk(2);
    apb(0, ASP_POS_OFS, 32'h0);
    check("actual", rd[15:0], 16'h0141);
    freeze <= 1'b0;
    apb(1, ASP_TFREQ_OFS, 32'h8);
    apb(1, ASP_TEST_OFS, {2'h1, 14'h64, 16'h0352});
    tk(4);
    scan(96, 750, mx, 1);
    check("sq_bad", bad, 0);
    check("sq_lo", lo, 750);
    check("sq_hi", hi, mx);
    check("sq_fast", chg >= 8, 1'b1);
    apb(1, ASP_TFREQ_OFS, 32'h800);
    scan(96, 750, mx, 1);
    check("sq_slow", chg <= 1, 1'b1);
    apb(1, ASP_TFREQ_OFS, 32'h20);
    apb(1, ASP_TEST_OFS, {2'h2, 14'h14, 16'h01F4});
    tk(25);
    scan(200, 480, 520, 0);
    check("tri_bad", bad, 0);
    check("tri_moves", chg > 20 && lo < hi, 1'b1);
    // Generator output ends the test unless stop is held
    setpoint_gen <= 16'h0005;
    ext_stop <= 1'b1;
    tk(2);
    apb(0, ASP_CTRL_OFS, 32'h0);
    check("stop_hold", rd[2], 1'b1);
    ext_stop <= 1'b0;
    tk(1);
    apb(0, ASP_CTRL_OFS, 32'h0);
    check("exit", rd[2], 1'b0);
    apb(1, ASP_CTRL_OFS, 32'h5);
    apb(0, ASP_CTRL_OFS, 32'h0);
    check("exit_wins", rd[2], 1'b0);
    setpoint_gen <= 16'h0000;
    // Gain factor against a jammed actuator
    apb(1, ASP_FILL_OFS, 32'h01F4);
    apb(1, ASP_CORR_OFS, {8'h0, 8'h40, 16'h0032});
    freeze <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      freeze_pos <= 16'(i == 0 ? 510 : i == 1 ? 700 : 575);
      tk(4);
      apb(0, ASP_STAT_OFS, 32'h0);
      if (i < 2)
        check("corr", rd[23:16], i ? 8'h80 : 8'h40);
      else
        check("blend", rd[23:16] > 64 && rd[23:16] < 128, 1'b1);
    end
    apb(1, ASP_CORR_OFS, {8'h0, 8'h80, 16'h0032});
    tk(4);
    apb(0, ASP_STAT_OFS, 32'h0);
    check("unity", rd[23:16], 8'h80);
    freeze <= 1'b0;
    // Current budget: delay, decay, restore on a new set position
    apb(1, ASP_CURR_OFS, {16'h0400, 16'hF000});
    apb(1, ASP_DELAY_OFS, 32'h190);
    apb(1, ASP_FILL_OFS, 32'h0258);
    tk(3);
    apb(0, ASP_STAT_OFS, 32'h0);
    check("full", rd[15:0], 16'hF000);
    tk(40);
    apb(0, ASP_STAT_OFS, 32'h0);
    check("delayed", rd[15:0], 16'hF000);
    tk(200);
    apb(0, ASP_STAT_OFS, 32'h0);
    check("decay", rd[15:0] < 16'hF000 && rd[15:0] >= 16'h0400, 1'b1);
    apb(1, ASP_FILL_OFS, 32'h0259);
    tk(3);
    apb(0, ASP_STAT_OFS, 32'h0);
    check("restored", rd[15:0], 16'hF000);
    apb(1, ASP_DELAY_OFS, 32'h0);
    apb(1, ASP_FILL_OFS, 32'h025A);
    tk(20);
    apb(0, ASP_STAT_OFS, 32'h0);
    check("no_delay", rd[15:0] < 16'hF000, 1'b1);
    end_of_test;
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test;
  end
endmodule
